// *** inc/btsk_cfg.svh ***
`ifndef BTSK_CFG_SVH
`define BTSK_CFG_SVH

// ****************************************
// Instruction encoding
// ****************************************
`define BTSK_OPC_CLR 4'hb
`define BTSK_OPC_SET 4'ha
`define BTSK_ILO_LIMIT 8'h5f
`define BTSK_ACC_LO_BASE 4'h0
`define BTSK_ACC_HI_BASE 4'hf
`define BTSK_2W_MOVE 4'hc
`define BTSK_2W_BRANCH 6'h3b
`define BTSK_2W_EXT 8'heb

// ****************************************
// Register map
// ****************************************
`define BTSK_REG_BANK 4'h0
`define BTSK_REG_CTRL 4'h1
`define BTSK_REG_INDEX 4'h2
`define BTSK_REG_STAT 4'h3
`define BTSK_CTRL_EXT_BIT 0
`define BTSK_STAT_SKIP_BIT 0
`define BTSK_STAT_NOP_BIT 1
`define BTSK_RST_BANK 4'h0
`define BTSK_RST_INDEX 12'h000
`define BTSK_RST_EXT 1'b0

`endif

// *** inc/btsk_pkg.sv ***
package btsk_pkg;

    typedef enum logic [3:0] {
        BTSK_Q1 = 4'b0001,
        BTSK_Q2 = 4'b0010,
        BTSK_Q3 = 4'b0100,
        BTSK_Q4 = 4'b1000
    } btsk_phase_t;

    typedef struct packed {
        btsk_phase_t phase;
        logic [2:0] bitidx;
        logic acc;
        logic [7:0] file;
        logic is_bt;
        logic is_set;
        logic hit;
        logic discard;
        logic flush2;
        logic [3:0] bank;
        logic ext_en;
        logic [11:0] idx;
        logic [7:0] skip_cnt;
        logic last_skip;
        logic [15:0] rdata;
        logic [11:0] mem_addr;
        logic mem_rd;
        logic skip_taken;
        logic word_ack;
    } btsk_state_t;

endpackage

// *** rtl/btsk_addr_gen.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "btsk_cfg.svh"

module btsk_addr_gen (
    input wire logic [7:0] file,
    input wire logic acc,
    input wire logic [3:0] bank,
    input wire logic ext_en,
    input wire logic [11:0] idx,
    output logic [11:0] addr
);
    always_comb begin
        if (acc) begin
            addr = {bank, file};
        end else if (ext_en && (file <= `BTSK_ILO_LIMIT)) begin
            addr = 12'(idx + {4'h0, file});
        end else if (file <= `BTSK_ILO_LIMIT) begin
            addr = {`BTSK_ACC_LO_BASE, file};
        end else begin
            addr = {`BTSK_ACC_HI_BASE, file};
        end
    end
endmodule

`default_nettype wire

// *** rtl/btsk_core.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "btsk_cfg.svh"

module btsk_core (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [15:0] instr_word,
    output logic word_ack,
    output logic nop_cycle,
    output logic skip_taken,
    output btsk_pkg::btsk_phase_t phase,
    output logic [11:0] mem_addr,
    output logic mem_rd,
    input wire logic [7:0] mem_rdata,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata
);
    import btsk_pkg::*;

    btsk_state_t s;
    btsk_state_t next_s;
    logic [11:0] calc_addr;
    logic tested_bit;
    logic word_is_bt;

    // ****************************************
    // Operand address
    // ****************************************
    btsk_addr_gen u_addr (
        .file(instr_word[7:0]),
        .acc(instr_word[8]),
        .bank(s.bank),
        .ext_en(s.ext_en),
        .idx(s.idx),
        .addr(calc_addr)
    );

    // Words that own a second program word; the extended move pair only counts
    // while the extended set is on, otherwise that code is a plain one-word op.
    function automatic logic two_word(input logic [15:0] w, input logic ext);
        two_word = (w[15:12] == `BTSK_2W_MOVE) ||
                   (w[15:10] == `BTSK_2W_BRANCH) ||
                   (ext && (w[15:8] == `BTSK_2W_EXT));
    endfunction

    assign word_is_bt = (instr_word[15:12] == `BTSK_OPC_CLR) ||
                        (instr_word[15:12] == `BTSK_OPC_SET);
    assign tested_bit = mem_rdata[s.bitidx];

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_s = s;
        next_s.mem_rd = 1'b0;
        next_s.skip_taken = 1'b0;
        next_s.word_ack = 1'b0;
        next_s.rdata = 16'h0000;
        unique case (s.phase)
            BTSK_Q1: begin
                next_s.phase = BTSK_Q2;
                next_s.bitidx = instr_word[11:9];
                next_s.acc = instr_word[8];
                next_s.file = instr_word[7:0];
                next_s.is_set = (instr_word[15:12] == `BTSK_OPC_SET);
                next_s.is_bt = word_is_bt && !s.discard;
                next_s.hit = 1'b0;
                if (word_is_bt && !s.discard) begin
                    next_s.mem_rd = 1'b1;
                    next_s.mem_addr = calc_addr;
                end
            end
            BTSK_Q2: begin
                next_s.phase = BTSK_Q3;
            end
            BTSK_Q3: begin
                next_s.phase = BTSK_Q4;
                if (s.is_bt) begin
                    // Data returned one edge after the read strobe
                    next_s.hit = s.is_set ? tested_bit : !tested_bit;
                end
            end
            BTSK_Q4: begin
                next_s.phase = BTSK_Q1;
                next_s.word_ack = 1'b1;
                if (s.discard) begin
                    // Second word of a skipped two-word op is flushed as well; that
                    // second word is raw operand data, so it must never chain a flush
                    next_s.discard = !s.flush2 && two_word(instr_word, s.ext_en);
                    next_s.flush2 = !s.flush2 && two_word(instr_word, s.ext_en);
                end else begin
                    next_s.discard = s.is_bt && s.hit;
                    next_s.flush2 = 1'b0;
                end
                if (!s.discard && s.is_bt) begin
                    next_s.last_skip = s.hit;
                    if (s.hit) begin
                        next_s.skip_taken = 1'b1;
                        next_s.skip_cnt = 8'(s.skip_cnt + 8'h01);
                    end
                end
            end
            default: begin
                next_s.phase = BTSK_Q1;
            end
        endcase

        // Register port; accesses never stall the instruction phases
        if (reg_wr) begin
            case (reg_addr)
                `BTSK_REG_BANK: next_s.bank = reg_wdata[3:0];
                `BTSK_REG_CTRL: next_s.ext_en = reg_wdata[`BTSK_CTRL_EXT_BIT];
                `BTSK_REG_INDEX: next_s.idx = reg_wdata[11:0];
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                `BTSK_REG_BANK: next_s.rdata = {12'h000, s.bank};
                `BTSK_REG_CTRL: next_s.rdata = {15'h0000, s.ext_en};
                `BTSK_REG_INDEX: next_s.rdata = {4'h0, s.idx};
                `BTSK_REG_STAT: next_s.rdata = {s.skip_cnt, 6'h00, s.discard, s.last_skip};
                default: next_s.rdata = 16'h0000;
            endcase
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            s <= '{
                phase: BTSK_Q1,
                bitidx: 3'h0,
                acc: 1'b0,
                file: 8'h00,
                is_bt: 1'b0,
                is_set: 1'b0,
                hit: 1'b0,
                discard: 1'b0,
                flush2: 1'b0,
                bank: `BTSK_RST_BANK,
                ext_en: `BTSK_RST_EXT,
                idx: `BTSK_RST_INDEX,
                skip_cnt: 8'h00,
                last_skip: 1'b0,
                rdata: 16'h0000,
                mem_addr: 12'h000,
                mem_rd: 1'b0,
                skip_taken: 1'b0,
                word_ack: 1'b0
            };
        end else begin
            s <= next_s;
        end
    end

    assign phase = s.phase;
    assign word_ack = s.word_ack;
    assign nop_cycle = s.discard;
    assign skip_taken = s.skip_taken;
    assign mem_addr = s.mem_addr;
    assign mem_rd = s.mem_rd;
    assign reg_rdata = s.rdata;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    a_clear_skip_taken: assert property (
        (s.phase == BTSK_Q3 && s.is_bt && !s.is_set && !tested_bit) |-> ##2 skip_taken
    ) else $error("clear test with bit low did not skip");

    a_set_skip_taken: assert property (
        (s.phase == BTSK_Q3 && s.is_bt && s.is_set && tested_bit) |-> ##2 skip_taken
    ) else $error("set test with bit high did not skip");

    a_skip_nop_cycle: assert property (
        skip_taken |-> (nop_cycle && !mem_rd)[*4]
    ) else $error("skipped word was not replaced by a no-operation cycle");

    a_two_word_flush: assert property (
        (s.phase == BTSK_Q4 && s.discard && !s.flush2 && two_word(instr_word, s.ext_en))
            |=> (nop_cycle && !skip_taken)[*4] ##1 !nop_cycle
    ) else $error("two-word successor not flushed for exactly one more cycle");

    a_bank_select_addr: assert property (
        (mem_rd && s.acc) |-> mem_addr[11:8] == $past(s.bank)
    ) else $error("banked access did not use the bank select value");

    a_indexed_offset: assert property (
        (mem_rd && !s.acc && $past(s.ext_en) && s.file <= `BTSK_ILO_LIMIT)
            |-> mem_addr == $past(s.idx) + {4'h0, s.file}
    ) else $error("indexed literal offset address wrong");

    a_no_skip_normal: assert property (
        (s.phase == BTSK_Q3 && s.is_bt && (s.is_set != tested_bit))
            |-> ##2 (!skip_taken && !nop_cycle && word_ack)
    ) else $error("failed test still skipped");

    a_read_in_q2: assert property (
        mem_rd |-> (phase == BTSK_Q2 && s.is_bt) ##1 (phase == BTSK_Q3 && !mem_rd)
    ) else $error("operand read outside the read phase");

    a_mem_rd_once: assert property (
        mem_rd |=> (!mem_rd)[*3]
    ) else $error("more than one operand read in one cycle");

    // ****************************************
    // Phase sequence
    // ****************************************
    a_phase_onehot: assert property (
        $onehot(phase)
    ) else $error("phase code is not one-hot");

    a_phase_q1_q2: assert property (
        (phase == BTSK_Q1) |=> (phase == BTSK_Q2)
    ) else $error("decode phase not followed by read phase");

    a_phase_q2_q3: assert property (
        (phase == BTSK_Q2) |=> (phase == BTSK_Q3)
    ) else $error("read phase not followed by test phase");

    a_phase_q3_q4: assert property (
        (phase == BTSK_Q3) |=> (phase == BTSK_Q4)
    ) else $error("test phase not followed by last phase");

    a_phase_q4_q1: assert property (
        (phase == BTSK_Q4) |=> (phase == BTSK_Q1)
    ) else $error("last phase not followed by decode phase");

    a_ack_in_q1: assert property (
        word_ack |-> (phase == BTSK_Q1)
    ) else $error("word acknowledge outside the decode phase");

    // The very first Q1 after reset carries no acknowledge, so key on Q4
    a_ack_every_cycle: assert property (
        (phase == BTSK_Q4) |=> word_ack
    ) else $error("instruction cycle ended without acknowledge");

    a_test_reads_file: assert property (
        (phase == BTSK_Q1 && !nop_cycle && word_is_bt) |=> mem_rd
    ) else $error("bit test word did not read its file byte");

    // ****************************************
    // Skip and flush
    // ****************************************
    a_skip_in_q1: assert property (
        skip_taken |-> (phase == BTSK_Q1 && word_ack && nop_cycle)
    ) else $error("skip pulse outside the first flushed phase");

    a_no_read_discard: assert property (
        (phase == BTSK_Q1 && nop_cycle) |=> !mem_rd
    ) else $error("discarded word still read data memory");

    a_single_skip: assert property (
        skip_taken |=> (!skip_taken)[*3]
    ) else $error("skip pulse longer than one cycle");

    a_skip_count_step: assert property (
        skip_taken |-> s.skip_cnt == 8'($past(s.skip_cnt) + 8'h01)
    ) else $error("skip count did not advance by one");

    // Bounds the flush: a second word never extends the no-operation run
    a_second_word_end: assert property (
        (phase == BTSK_Q4 && s.flush2) |=> !nop_cycle
    ) else $error("flush ran past the second word");

    // ****************************************
    // Operand address
    // ****************************************
    a_access_low_addr: assert property (
        (mem_rd && !s.acc && !$past(s.ext_en) && s.file <= `BTSK_ILO_LIMIT)
            |-> mem_addr == {`BTSK_ACC_LO_BASE, s.file}
    ) else $error("lower access bank address wrong");

    a_access_high_addr: assert property (
        (mem_rd && !s.acc && s.file > `BTSK_ILO_LIMIT)
            |-> mem_addr == {`BTSK_ACC_HI_BASE, s.file}
    ) else $error("upper access bank address wrong");

    c_skip_seen: cover property (skip_taken);
    c_second_word: cover property (s.flush2 && phase == BTSK_Q4);
    c_two_word_flush: cover property (skip_taken ##4 nop_cycle);
    c_indexed_read: cover property (mem_rd && !s.acc && s.ext_en && s.file <= `BTSK_ILO_LIMIT);

endmodule

`default_nettype wire

// *** dv/btsk_mem_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module btsk_mem_model (
    input wire logic clk_sys,
    input wire logic [11:0] mem_addr,
    input wire logic mem_rd,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [0:4095];
    // Outside the answer cycle the byte flips, so a late sample never passes by luck
    always @(posedge clk_sys) begin
        if (mem_rd === 1'h1) begin
            mem_rdata <= mem[mem_addr];
        end else begin
            mem_rdata <= ~mem_rdata;
        end
    end
    initial begin
        mem_rdata = 8'h00;
        foreach (mem[i]) begin
            mem[i] = 8'h00;
        end
    end
endmodule
`default_nettype wire

// *** dv/test_bit_test_skip_instructions.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_bit_test_skip_instructions;
    import btsk_pkg::*;
    typedef struct packed {
        logic [15:0] w;
        logic [3:0] bank;
        logic ext;
        logic [11:0] addr;
        logic [7:0] mv;
        logic sk;
    } btsk_row_t;
    logic clk_sys;
    logic rst_b = 1'h0;
    logic [15:0] instr_word = 16'h0000;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic word_ack, nop_cycle, skip_taken, mem_rd;
    btsk_phase_t phase;
    logic [11:0] mem_addr, rd_addr;
    logic [7:0] mem_rdata;
    logic [15:0] reg_rdata;
    int num_errors = 0, n_tests = 0, rd_cnt = 0, cyc = 0, nsk = 0;
    btsk_row_t rows [8] = '{
        '{16'hb620, 4'h0, 1'h0, 12'h020, 8'hf7, 1'h1},
        '{16'hb620, 4'h0, 1'h0, 12'h020, 8'h08, 1'h0},
        '{16'haf81, 4'h5, 1'h0, 12'h581, 8'h80, 1'h1},
        '{16'ha181, 4'h5, 1'h0, 12'h581, 8'hfe, 1'h0},
        '{16'ha2a0, 4'h5, 1'h0, 12'hfa0, 8'h02, 1'h1},
        '{16'hb45f, 4'h5, 1'h1, 12'h15f, 8'hfb, 1'h1},
        '{16'hb460, 4'h5, 1'h1, 12'hf60, 8'hff, 1'h0},
        '{16'hb45f, 4'h5, 1'h0, 12'h05f, 8'hff, 1'h0}};

    btsk_core DUT (.clk_sys(clk_sys), .rst_b(rst_b), .instr_word(instr_word),
        .word_ack(word_ack), .nop_cycle(nop_cycle), .skip_taken(skip_taken), .phase(phase),
        .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    btsk_mem_model mem_model (.clk_sys(clk_sys), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_rdata(mem_rdata));

    // ****
    // Clock, read monitor, watchdog
    // ****
    initial begin
        clk_sys = 1'h0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (mem_rd === 1'h1) begin
            if (rd_cnt == 0) rd_addr <= mem_addr;
            rd_cnt <= rd_cnt + 1;
        end
        if (cyc == 4000) begin
            num_errors++;
            close_out;
        end
    end

    // ****
    // Tasks
    // ****
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task close_out;
        $display("comparisons=%0d mismatches=%0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clk_sys);
        reg_wr <= 1'h0;
    endtask
    task rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk_sys);
        reg_rd <= 1'h0;
        @(negedge clk_sys);
        chk(reg_rdata, exp);
    endtask
    // New word lands on the edge that opens Q1, held for the whole cycle
    task step(input logic [15:0] w);
        @(negedge clk_sys);
        while (phase !== BTSK_Q4) @(negedge clk_sys);
        @(posedge clk_sys);
        instr_word <= w;
    endtask

    // ****
    // Sequence
    // ****
    initial begin
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'h1;
        @(negedge clk_sys);
        chk({phase, word_ack, nop_cycle, skip_taken, mem_rd}, {BTSK_Q1, 4'h0});
        for (int a = 0; a < 3; a++) rd(4'(a), 16'h0000);
        rd(4'h9, 16'h0000);
        wr(4'h2, 16'h0100);
        $display("reset test done");
        foreach (rows[i]) begin
            wr(4'h0, {12'h000, rows[i].bank});
            wr(4'h1, {15'h0000, rows[i].ext});
            mem_model.mem[rows[i].addr] = rows[i].mv;
            rd_cnt = 0;
            step(rows[i].w);
            step(16'ha000);
            @(negedge clk_sys);
            chk({skip_taken, nop_cycle, word_ack}, {rows[i].sk, rows[i].sk, 1'h1});
            step(16'h0000);
            @(negedge clk_sys);
            chk({rd_addr, 4'(rd_cnt)}, {rows[i].addr, rows[i].sk ? 4'h1 : 4'h2});
            nsk += rows[i].sk;
            $display("row %0d done", i);
        end
        wr(4'h1, 16'h0000);
        mem_model.mem[12'h020] = 8'h00;
        rd_cnt = 0;
        step(16'hb620);
        step(16'hc123);
        @(negedge clk_sys);
        chk({skip_taken, nop_cycle}, 2'h3);
        step(16'hb620);
        @(negedge clk_sys);
        chk({skip_taken, nop_cycle}, 2'h1);
        step(16'h0000);
        @(negedge clk_sys);
        chk({nop_cycle, word_ack, 4'(rd_cnt)}, 6'h11);
        nsk++;
        wr(4'h1, 16'h0001);
        mem_model.mem[12'h120] = 8'h00;
        step(16'hb620);
        step(16'heb00);
        @(negedge clk_sys);
        chk({skip_taken, nop_cycle}, 2'h3);
        step(16'hc000);
        @(negedge clk_sys);
        chk({skip_taken, nop_cycle}, 2'h1);
        step(16'h0000);
        @(negedge clk_sys);
        chk({nop_cycle, word_ack}, 2'h1);
        nsk++;
        wr(4'h3, 16'hffff);
        rd(4'h3, {8'(nsk), 8'h01});
        $display("two-word skip test done");
        close_out;
    end
endmodule
`default_nettype wire
